// [common/sac_defines.vh]
// Constants for the successive-approximation converter control block.
// Included by the control logic; holds definitions only.
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// Register indices; byte address on the bus is four times the index
`define SAC_IDX_CONTROL      16'hFE58
`define SAC_IDX_MODE         16'hFE59
`define SAC_IDX_RESULT_LOW   16'hFE5A
`define SAC_IDX_RESULT_HIGH  16'hFE5B
`define SAC_IDX_W            16

// Reset values
`define SAC_RST_CONTROL      8'h00
`define SAC_RST_MODE         8'h00
`define SAC_RST_RESULT_LOW   8'h00
`define SAC_RST_RESULT_HIGH  8'h00

// Control register fields
`define SAC_CTL_CHSEL_HI     7
`define SAC_CTL_CHSEL_LO     4
`define SAC_CTL_GO           2
`define SAC_CTL_DONE         1
`define SAC_CTL_IRQ_EN       0

// Mode register fields
`define SAC_MODE_RES         6
`define SAC_MODE_DIV_HI      1
`define SAC_MODE_DIV_LO      0

// Low result register fields
`define SAC_LOW_DATA_HI      7
`define SAC_LOW_DATA_LO      4
`define SAC_LOW_DIV_B2       0

// Conversion time figures, in units of one third of an instruction cycle
`define SAC_UNITS_12BIT      15'h0034
`define SAC_UNITS_8BIT       15'h0020
`define SAC_UNITS_SETTLE     15'h0002

// Clock cycles per third of an instruction cycle
`define SAC_UNIT_CYCLES      4'h1

// Successive-approximation bit positions
`define SAC_MSB              4'hB
`define SAC_LSB_12BIT        4'h0
`define SAC_LSB_8BIT         4'h4

`endif

// [logic/sac_adc_control.v]
// Control logic of a 12-bit successive-approximation converter with
// an 8-bit mode, four byte registers behind an Avalon-MM slave.
// Assumes the analog multiplexer, reference ladder and comparator sit
// outside and answer combinationally within one clock.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

`include "sac_defines.vh"

// How it works
// - Control bits 7..4 choose the analog channel driven to the multiplexer.
// - Writing 1 to conv_go starts a conversion on the selected channel.
// - Hardware clears conv_go when the conversion finishes.
// - Writing 0 to conv_go aborts a running conversion; result invalid.
// - conv_done_flag sets when a conversion completes.
// - conv_done_flag stays set until software writes 0 to it.
// - Interrupt request while conv_done_flag and done_irq_enable are both 1.
// - Mode bit 6 selects 12-bit (0) or 8-bit (1) resolution.
// - 8-bit result goes to the high register; low register left alone.
// - 12-bit result: upper eight bits high, lower four in low bits 7..4.
// - Three-bit divider code selects ratios 1/1 up to 1/128.
// - 12-bit time is (52/ratio + 2) thirds of an instruction cycle.
// - 8-bit time is (32/ratio + 2) thirds of an instruction cycle.
// - Time doubles for first 12-bit conversion after reset or 8-to-12 switch.
// - Reference ladder enabled while a conversion runs, off otherwise.
// - Reset during a conversion clears conv_go and halts the converter.
module sac_adc_control #(
   parameter [3:0] UNIT_CYCLES = `SAC_UNIT_CYCLES
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire [17:0] avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        comparator_high,
   output wire [3:0]  channel_mux,
   output wire        ladder_enable,
   output wire [11:0] ladder_mux,
   output wire        conv_irq
);

   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;
   localparam [11:0] SAR_FIRST = 12'h800;
   localparam [3:0]  UNIT_LAST = UNIT_CYCLES - 4'h1;

   // Reset images of the byte registers; slicing them keeps widths exact
   localparam [7:0] RST_CTL  = `SAC_RST_CONTROL;
   localparam [7:0] RST_MODE = `SAC_RST_MODE;
   localparam [7:0] RST_LOW  = `SAC_RST_RESULT_LOW;
   localparam [7:0] RST_HIGH = `SAC_RST_RESULT_HIGH;

   // Register index match on an aligned byte address
   function hit;
      input [17:0]              addr;
      input [`SAC_IDX_W-1:0]    idx;
      begin
         hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
      end
   endfunction

   reg  [3:0]  channel_select_r;
   reg         conv_go_r;
   reg         conv_done_flag_r;
   reg         done_irq_enable_r;
   reg         resolution_select_r;
   reg  [1:0]  divider_code_lo_r;
   reg         divider_code_b2_r;
   reg  [3:0]  result_low_nibble_r;
   reg  [7:0]  result_high_r;
   reg         first_12bit_r;
   reg         state_r;
   reg  [3:0]  unit_pre_r;
   reg  [14:0] unit_cnt_r;
   reg  [7:0]  div_cnt_r;
   reg  [11:0] sar_r;
   reg  [3:0]  bit_idx_r;
   reg         bits_done_r;
   reg         ack_r;

   // Settings latched at start, so a mode write mid-conversion is harmless
   reg         conv_res_r;
   reg  [2:0]  conv_div_r;
   reg         conv_dbl_r;

   // Decode and timing nets
   wire        req;
   wire        wr_ok;
   wire        wr_ctl;
   wire        wr_mode;
   wire        wr_low;
   wire        wr_high;
   wire [7:0]  wdat;
   wire [2:0]  div_code;
   wire        unit_tick;
   wire [14:0] base_units;
   wire [14:0] norm_units;
   wire [14:0] total_units;
   wire        dbl_time;
   wire [7:0]  div_last;
   wire        step;
   wire [3:0]  lsb_idx;
   wire        finish;
   wire        start;
   wire        abort;
   reg  [7:0]  rd_byte;
   genvar      gi;

   // Two-cycle handshake: waitrequest high in the first cycle of a request
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_ok           = avs_write & ack_r & avs_byteenable[0];
   assign wdat            = avs_writedata[7:0];
   assign wr_ctl  = wr_ok & hit(avs_address, `SAC_IDX_CONTROL);
   assign wr_mode = wr_ok & hit(avs_address, `SAC_IDX_MODE);
   assign wr_low  = wr_ok & hit(avs_address, `SAC_IDX_RESULT_LOW);
   assign wr_high = wr_ok & hit(avs_address, `SAC_IDX_RESULT_HIGH);

   // ack_r marks the answer cycle and drops with it
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Fixed bits are not stored and read back as zero
   always @* begin
      rd_byte = 8'h00;
      if (hit(avs_address, `SAC_IDX_CONTROL)) begin
         rd_byte = {channel_select_r, 1'b0, conv_go_r,
                    conv_done_flag_r, done_irq_enable_r};
      end else if (hit(avs_address, `SAC_IDX_MODE)) begin
         rd_byte = {1'b0, resolution_select_r, 4'h0, divider_code_lo_r};
      end else if (hit(avs_address, `SAC_IDX_RESULT_LOW)) begin
         rd_byte = {result_low_nibble_r, 3'b000, divider_code_b2_r};
      end else if (hit(avs_address, `SAC_IDX_RESULT_HIGH)) begin
         rd_byte = result_high_r;
      end
   end

   // Unmapped addresses read as zero
   // Loaded in the wait cycle, so it stands through the answer cycle
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~ack_r) begin
         avs_readdata <= {24'h000000, rd_byte};
      end
   end

   // Conversion timing
   assign div_code   = conv_div_r;
   assign base_units = conv_res_r ? `SAC_UNITS_8BIT
                                  : `SAC_UNITS_12BIT;
   // Dividing by a ratio of 1/2^n is a left shift by n
   assign norm_units = (base_units << div_code) + `SAC_UNITS_SETTLE;
   assign dbl_time   = conv_dbl_r;
   assign total_units = dbl_time ? {norm_units[13:0], 1'b0} : norm_units;
   assign div_last   = (8'h01 << div_code) - 8'h01;
   // The prescaler lets a faster clock stand in for a third of Tcyc
   assign unit_tick  = (unit_pre_r == UNIT_LAST);
   assign lsb_idx    = conv_res_r ? `SAC_LSB_8BIT
                                  : `SAC_LSB_12BIT;
   // Trials fall on the last unit of each divided period
   assign step       = (state_r == ST_CONV) & unit_tick & ~bits_done_r &
                       (unit_cnt_r >= `SAC_UNITS_SETTLE) &
                       (div_cnt_r == div_last);
   assign finish     = (state_r == ST_CONV) & unit_tick &
                       (unit_cnt_r == total_units - 15'h0001);
   assign start      = wr_ctl & wdat[`SAC_CTL_GO] &
                       (state_r == ST_IDLE);
   // A clear on the finishing edge loses, so a good result is kept
   assign abort      = wr_ctl & ~wdat[`SAC_CTL_GO] &
                       (state_r == ST_CONV) & ~finish;

   // Sequencer
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r     <= ST_IDLE;
         unit_pre_r  <= 4'h0;
         unit_cnt_r  <= 15'h0000;
         div_cnt_r   <= 8'h00;
         sar_r       <= 12'h000;
         bit_idx_r   <= 4'h0;
         bits_done_r <= 1'b0;
         conv_res_r  <= 1'b0;
         conv_div_r  <= 3'b000;
         conv_dbl_r  <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r     <= ST_CONV;
                  unit_pre_r  <= 4'h0;
                  unit_cnt_r  <= 15'h0000;
                  div_cnt_r   <= 8'h00;
                  sar_r       <= SAR_FIRST;
                  bit_idx_r   <= `SAC_MSB;
                  conv_res_r  <= resolution_select_r;
                  conv_div_r  <= {divider_code_b2_r, divider_code_lo_r};
                  conv_dbl_r  <= first_12bit_r & ~resolution_select_r;
                  bits_done_r <= 1'b0;
               end
            end
            ST_CONV: begin
               // The unit counter runs on after the last trial until finish
               if (finish | abort) begin
                  state_r <= ST_IDLE;
               end else begin
                  if (unit_tick) begin
                     unit_pre_r <= 4'h0;
                     unit_cnt_r <= unit_cnt_r + 15'h0001;
                     if (unit_cnt_r >= `SAC_UNITS_SETTLE) begin
                        div_cnt_r <= (div_cnt_r == div_last) ? 8'h00
                                     : div_cnt_r + 8'h01;
                     end
                  end else begin
                     unit_pre_r <= unit_pre_r + 4'h1;
                  end
                  // Keep the trial bit if the input is above it
                  if (step) begin
                     sar_r[bit_idx_r] <= comparator_high;
                     if (bit_idx_r == lsb_idx) begin
                        bits_done_r <= 1'b1;
                     end else begin
                        sar_r[bit_idx_r - 4'h1] <= 1'b1;
                        bit_idx_r <= bit_idx_r - 4'h1;
                     end
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Control register
   // A control write also takes the channel and the interrupt enable
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         channel_select_r  <= RST_CTL[`SAC_CTL_CHSEL_HI:`SAC_CTL_CHSEL_LO];
         conv_go_r         <= 1'b0;
         conv_done_flag_r  <= RST_CTL[`SAC_CTL_DONE];
         done_irq_enable_r <= RST_CTL[`SAC_CTL_IRQ_EN];
      end else begin
         if (wr_ctl) begin
            channel_select_r  <=
               wdat[`SAC_CTL_CHSEL_HI:`SAC_CTL_CHSEL_LO];
            done_irq_enable_r <= wdat[`SAC_CTL_IRQ_EN];
         end
         if (finish) begin
            conv_go_r <= 1'b0;
         end else if (start) begin
            conv_go_r <= 1'b1;
         end else if (abort) begin
            conv_go_r <= 1'b0;
         end
         // Completion wins over a same-cycle clear so no event is lost
         if (finish) begin
            conv_done_flag_r <= 1'b1;
         end else if (wr_ctl & ~wdat[`SAC_CTL_DONE]) begin
            conv_done_flag_r <= 1'b0;
         end
      end
   end

   // Mode register and first-conversion tracking
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         resolution_select_r <= RST_MODE[`SAC_MODE_RES];
         divider_code_lo_r   <= RST_MODE[`SAC_MODE_DIV_HI:`SAC_MODE_DIV_LO];
         first_12bit_r       <= 1'b1;
      end else begin
         if (wr_mode) begin
            resolution_select_r <= wdat[`SAC_MODE_RES];
            divider_code_lo_r   <=
               wdat[`SAC_MODE_DIV_HI:`SAC_MODE_DIV_LO];
         end
         // Only an 8-to-12 switch rearms the doubled time
         if (wr_mode & resolution_select_r & ~wdat[`SAC_MODE_RES]) begin
            first_12bit_r <= 1'b1;
         end else if (finish & ~conv_res_r) begin
            first_12bit_r <= 1'b0;
         end
      end
   end

   // Result registers; hardware write wins over a same-cycle bus write
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_low_nibble_r <= RST_LOW[`SAC_LOW_DATA_HI:`SAC_LOW_DATA_LO];
         divider_code_b2_r   <= RST_LOW[`SAC_LOW_DIV_B2];
         result_high_r       <= RST_HIGH;
      end else begin
         if (wr_low) begin
            divider_code_b2_r <= wdat[`SAC_LOW_DIV_B2];
         end
         if (finish) begin
            result_high_r <= sar_r[11:4];
            // In 8-bit mode the low nibble keeps what software left there
            if (~conv_res_r) begin
               result_low_nibble_r <= sar_r[3:0];
            end
         end else begin
            if (wr_low) begin
               result_low_nibble_r <=
                  wdat[`SAC_LOW_DATA_HI:`SAC_LOW_DATA_LO];
            end
            if (wr_high) begin
               result_high_r <= wdat;
            end
         end
      end
   end

   // Analog side
   // Channel follows the register at once; change it only while idle
   assign channel_mux   = channel_select_r;
   assign ladder_enable = (state_r == ST_CONV);
   // Trial bits park at zero when idle so the reference draws nothing
   generate
      for (gi = 0; gi < 12; gi = gi + 1) begin : g_park
         assign ladder_mux[gi] = ladder_enable & sar_r[gi];
      end
   endgenerate
   assign conv_irq      = conv_done_flag_r & done_irq_enable_r;

endmodule // sac_adc_control

`default_nettype wire

// [tb/sac_adc_props.sv]
// Port checker for the converter control block.
// Assumes it is bound to sac_adc_control on a single clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.vh"
module sac_adc_props #(
   parameter [3:0] UNIT_CYCLES = 4'h1
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [17:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        comparator_high,
   input wire logic [3:0]  channel_mux,
   input wire logic        ladder_enable,
   input wire logic [11:0] ladder_mux,
   input wire logic        conv_irq
);
   localparam [17:0] CTL_A = {`SAC_IDX_CONTROL, 2'b00};
   wire acc = (avs_read | avs_write) & ~avs_waitrequest;
   wire ctl_wr = acc & avs_write & avs_byteenable[0] & (avs_address == CTL_A);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
   read_upper_a: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h0) else $error("upper read lanes set");
   go_start_a: assert property (
      ctl_wr && avs_writedata[2] && !ladder_enable |=> ladder_enable)
      else $error("conversion did not start");
   go_abort_a: assert property (
      ctl_wr && !avs_writedata[2] && ladder_enable |=> !ladder_enable)
      else $error("conversion not stopped");
   irq_level_a: assert property (
      avs_read && !avs_waitrequest && avs_address == CTL_A
      |-> $past(conv_irq) == (avs_readdata[1] & avs_readdata[0]))
      else $error("irq differs from flag and enable");
   msb_first_a: assert property (
      $rose(ladder_enable) |-> ladder_mux == 12'h800)
      else $error("first trial is not the top bit");
   ladder_idle_a: assert property (
      !ladder_enable |-> ladder_mux == 12'h000)
      else $error("trial code while ladder off");
   chan_write_a: assert property (
      $changed(channel_mux) |-> $past(ctl_wr))
      else $error("channel moved without a write");
   conv_min_a: assert property (
      $rose(ladder_enable) |-> ladder_enable[*8])
      else $error("conversion too short");
   cover property ($rose(ladder_enable));
   cover property ($fell(ladder_enable) ##1 conv_irq);
   cover property (ctl_wr && ladder_enable);
endmodule // sac_adc_props
`default_nettype wire

// [tb/sac_analog_model.sv]
// Behavioural comparator and input voltages on the analog side.
// Assumes the trial code is settled within one clock.
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model (
   input wire logic        clk,
   input wire logic [3:0]  channel_mux,
   input wire logic        ladder_enable,
   input wire logic [11:0] ladder_mux,
   output logic            comparator_high
);
   logic        idle_r = 1'b0;
   logic [11:0] vin;
   // Each channel carries its own level so a wrong channel shows up
   assign vin = {channel_mux, ~channel_mux, channel_mux ^ 4'h6};
   always @(posedge clk) idle_r <= ~idle_r;
   // Ladder off: output wanders, so a stray sample is never a safe 0
   assign comparator_high = ladder_enable ? (vin >= ladder_mux) : idle_r;
endmodule // sac_analog_model
`default_nettype wire

// [tb/sac_adc_control_tb_top.sv]
// Testbench: register accesses over Avalon-MM and conversion checks.
// Assumes the analog model answers the ladder within one clock.
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.vh"
module sac_adc_control_tb_top;
   localparam logic [15:0] CT = `SAC_IDX_CONTROL;
   localparam logic [15:0] MD = `SAC_IDX_MODE;
   localparam logic [15:0] LO = `SAC_IDX_RESULT_LOW;
   localparam logic [15:0] HI = `SAC_IDX_RESULT_HIGH;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [17:0] avs_address = 18'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire         comparator_high;
   wire  [3:0]  channel_mux;
   wire         ladder_enable;
   wire  [11:0] ladder_mux;
   wire         conv_irq;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          busy_n = 0;
   logic [7:0]  rd;
   logic [11:0] v;
   logic [3:0]  ch;
   logic [2:0]  d;
   always #20 clk = ~clk;
   always @(posedge clk) if (ladder_enable) busy_n <= busy_n + 1;
   sac_adc_control #(.UNIT_CYCLES(4'h1)) dut (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .comparator_high(comparator_high),
      .channel_mux(channel_mux), .ladder_enable(ladder_enable),
      .ladder_mux(ladder_mux), .conv_irq(conv_irq));
   sac_analog_model u_model (.clk(clk), .channel_mux(channel_mux),
      .ladder_enable(ladder_enable), .ladder_mux(ladder_mux),
      .comparator_high(comparator_high));
   function automatic logic [11:0] vin(input logic [3:0] c);
      return {c, ~c, c ^ 4'h6};
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_checks++;
      if (seen !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, e, seen);
      end
   endtask
   task bus(input logic w, input logic [15:0] a, input logic [7:0] wd,
            input logic [3:0] be);
      int t;
      t = 0;
      @(posedge clk);
      avs_address <= {a, 2'b00};
      avs_read <= ~w;
      avs_write <= w;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 50);
      chk("waitrequest", avs_waitrequest, 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] wd);
      bus(1'b1, a, wd, 4'h1);
   endtask
   task rdx(input string nm, input logic [15:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'h1);
      chk(nm, rd, e);
   endtask
   // Start, then wait for the ladder to drop, with a bound
   task conv(input logic [7:0] c, input int n);
      int t;
      int b0;
      t = 0;
      b0 = busy_n;
      wr(CT, c);
      @(posedge clk);
      while (ladder_enable === 1'b1 && t < 20000) begin
         @(posedge clk);
         t++;
      end
      chk("conversion cycles", busy_n - b0, n);
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #1200000;
      n_mismatch++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b1, HI, 8'hC3, 4'h0);
      wr(16'hFE5C, 8'hFF);
      for (int i = 0; i < 5; i++) rdx("reset value", CT + i, 8'h00);
      chk("irq", conv_irq, 1'b0);
      $display("reset test done");
      conv(8'h55, 108);
      v = vin(4'h5);
      chk("channel", channel_mux, 4'h5);
      chk("irq", conv_irq, 1'b1);
      rdx("control", CT, 8'h53);
      rdx("high", HI, v[11:4]);
      rdx("low", LO, {v[3:0], 4'h0});
      wr(CT, 8'h52);
      rdx("control", CT, 8'h52);
      chk("irq", conv_irq, 1'b0);
      wr(CT, 8'h50);
      rdx("control", CT, 8'h50);
      wr(MD, 8'h01); // Ratio 1/2 in 12-bit mode
      conv(8'hB4, 106);
      rdx("high", HI, 8'hB4);
      rdx("low", LO, 8'hD0);
      $display("12-bit test done");
      wr(CT, 8'h04);
      repeat (20) @(posedge clk);
      wr(CT, 8'h00);
      @(posedge clk);
      chk("ladder", ladder_enable, 1'b0);
      rdx("control", CT, 8'h00);
      rdx("high", HI, 8'hB4);
      $display("abort test done");
      for (int k = 0; k < 8; k++) begin
         d = k;
         ch = (k < 7) ? d : 4'h8; // Codes 1110 and 1111 never used
         wr(MD, {6'h10, d[1:0]}); // Fixed bits written 0
         wr(LO, {4'hA, 3'h0, d[2]});
         conv({ch, 4'h4}, (32 << k) + 2);
         v = vin(ch);
         rdx("high", HI, v[11:4]);
         rdx("low", LO, {4'hA, 3'h0, d[2]});
         rdx("control", CT, {ch, 4'h2});
         wr(CT, {ch, 4'h0});
      end
      $display("8-bit test done");
      wr(MD, 8'h00);
      wr(LO, 8'h00);
      conv(8'h94, 108);
      rdx("high", HI, 8'h96);
      rdx("low", LO, 8'hF0);
      wr(CT, 8'hA4);
      repeat (10) @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      chk("ladder", ladder_enable, 1'b0);
      rdx("control", CT, 8'h00);
      conv(8'hA4, 108);
      rdx("high", HI, 8'hA5);
      rdx("control", CT, 8'hA2);
      $display("reset and switch test done");
      results();
   end
endmodule // sac_adc_control_tb_top
bind sac_adc_control sac_adc_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
   .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .comparator_high(comparator_high), .channel_mux(channel_mux),
   .ladder_enable(ladder_enable), .ladder_mux(ladder_mux),
   .conv_irq(conv_irq));
`default_nettype wire
